/* File: opled_pkg.sv */
// How it works
// - Strap form latched at reset, held after
// - Serial bits active low, bi-color link and speed bits excepted
// - Strap picks 3-bit, 2-bit, bi-color, 1-bit stream
// - Ports 0 to 7, collision bit first in 3-bit and bi-color
// - Collision blinks, else low full, high half
// - 3-bit link bit low, blinks on traffic
// - Bi-color link bit high 100M, low 10M
// - Speed and link bits drive LED pair
// - Serial speed low 100M, high 10M
// - Combined bit: 43 ms or 120 ms by speed
// - Period select zero means 120 ms
// - Strap picks scan line meaning, 11 reserved
// - Scan link lines high, bi-color one only at 100M; speed high 100M
// - Scan duplex high full, blinks on collision
// - Scan receive and transmit lines show activity
package opled_pkg;
    // Clock and blink timing
    localparam int CLK_PERIOD_NS  = 4;        // 250 MHz clock
    localparam int TICK_NS        = 1000000;  // One millisecond
    localparam int CYC_PER_MS     = TICK_NS / CLK_PERIOD_NS;
    localparam int BLINK_FAST_MS  = 43;       // Fast blink period
    localparam int BLINK_SLOW_MS  = 120;      // Slow blink period
    localparam int SHIFT_DIV      = 8;        // Cycles per serial bit
    localparam int SCAN_DIV       = 64;       // Cycles per scanned port
    localparam int NUM_PORTS      = 8;        // Ports served
    // Register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0; // Control
    localparam logic [3:0] REG_STATUS = 4'h4; // Block state
    localparam logic [3:0] REG_PORTS  = 4'h8; // Port link and speed
    // Control fields and reset values
    localparam int CTRL_BLINK_BIT   = 0;      // blink_period_select
    localparam int CTRL_SCAN_BIT    = 1;      // Scan form enable
    localparam logic CTRL_BLINK_RST = 1'b1;   // 43 ms after reset
    localparam logic CTRL_SCAN_RST  = 1'b0;   // Serial form after reset
    // Strap encodings
    localparam logic [1:0] FORM_3BIT = 2'h0;  // 3-bit / scan mode 0
    localparam logic [1:0] FORM_2BIT = 2'h1;  // 2-bit / scan mode 1
    localparam logic [1:0] FORM_BI   = 2'h2;  // Bi-color / scan mode 2
    localparam logic [1:0] FORM_1BIT = 2'h3;  // 1-bit / reserved
    // Serial shifter states
    typedef enum logic [2:0] {
        SH_IDLE  = 3'h1,
        SH_SHIFT = 3'h2,
        SH_LATCH = 3'h4
    } opled_sh_t;
endpackage

/* File: opled_blink_if.sv */
`timescale 1ns/1ps
// Shared blink timebase between generator and LED logic
interface opled_blink_if;
    logic tick;     // One-cycle millisecond pulse
    logic ph_fast;  // Toggles every 43 ms
    logic ph_slow;  // Toggles every 120 ms
    modport gen (output tick, output ph_fast, output ph_slow);
    modport use_ (input tick, input ph_fast, input ph_slow);
endinterface

/* File: opled_blink.sv */
`timescale 1ns/1ps
module opled_blink
    import opled_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS  // Clock cycles per millisecond
) (
    input  wire logic   clk_i,  // Clock
    input  wire logic   rst_i,  // Synchronous reset
    input  wire logic   ce_i,   // Clock enable
    opled_blink_if.gen  bl      // Blink timebase out
);
    logic [19:0] cyc_q;   // Cycles within a millisecond
    logic [6:0]  fast_q;  // Milliseconds within fast period
    logic [6:0]  slow_q;  // Milliseconds within slow period
    logic        tick_q;  // Millisecond pulse
    logic        pf_q;    // Fast phase
    logic        ps_q;    // Slow phase

    // Free-running millisecond divider shared by every port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            tick_q <= (cyc_q == 20'(CYC_MS - 1));
            if (cyc_q == 20'(CYC_MS - 1)) begin
                cyc_q <= '0;
            end else begin
                cyc_q <= cyc_q + 20'h1;
            end
        end
    end

    // Both phases step on the same tick, so all LEDs stay in step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_q <= '0;
            slow_q <= '0;
            pf_q   <= 1'b0;
            ps_q   <= 1'b0;
        end else if (ce_i && tick_q) begin
            if (fast_q == 7'(BLINK_FAST_MS - 1)) begin
                fast_q <= '0;
                pf_q   <= ~pf_q;
            end else begin
                fast_q <= fast_q + 7'h1;
            end
            if (slow_q == 7'(BLINK_SLOW_MS - 1)) begin
                slow_q <= '0;
                ps_q   <= ~ps_q;
            end else begin
                slow_q <= slow_q + 7'h1;
            end
        end
    end

    assign bl.tick    = tick_q;
    assign bl.ph_fast = pf_q;
    assign bl.ph_slow = ps_q;

    // Phases move only on a millisecond tick
    a_phase_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(pf_q) || $changed(ps_q) |-> $past(tick_q))
        else $error("blink phase changed without tick");
endmodule

/* File: opled_top.sv */
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module opled_top
    import opled_pkg::*;
#(
    parameter int CYC_MS  = CYC_PER_MS, // Cycles per millisecond
    parameter int SH_DIV  = SHIFT_DIV,  // Cycles per serial bit
    parameter int SC_DIV  = SCAN_DIV    // Cycles per scanned port
) (
    input  wire logic        clk_i,          // Clock, 250 MHz
    input  wire logic        rst_i,          // Sync reset, active high
    input  wire logic        ce_i,           // Clock enable
    input  wire logic [1:0]  led_form_strap_i, // Form strap pins
    input  wire logic [7:0]  link_i,         // Link up per port
    input  wire logic [7:0]  spd100_i,       // 100 Mbps per port
    input  wire logic [7:0]  full_dup_i,     // Full duplex per port
    input  wire logic [7:0]  col_i,          // Collision per port
    input  wire logic [7:0]  rx_act_i,       // Receive activity
    input  wire logic [7:0]  tx_act_i,       // Transmit activity
    input  wire logic        wb_cyc_i,       // Wishbone cycle
    input  wire logic        wb_stb_i,       // Wishbone strobe
    input  wire logic        wb_we_i,        // Wishbone write
    input  wire logic [3:0]  wb_adr_i,       // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic      [31:0] wb_dat_o,       // Wishbone read data
    output logic             wb_ack_o,       // Wishbone acknowledge
    output logic             led_sclk_o,     // Serial shift clock
    output logic             led_sdata_o,    // Serial data
    output logic             led_latch_o,    // Serial frame latch
    output logic      [7:0]  scan_sel_o,     // Scan port select
    output logic      [2:0]  scan_status_o   // Scan status lines
);
    // Strap capture
    logic [1:0] strap_m_q;   // First synchroniser stage
    logic [1:0] strap_s_q;   // Second synchroniser stage
    logic [1:0] form_q;      // Latched output form
    logic       form_done_q; // Strap already taken

    // Registers
    logic       blink_sel_q; // blink_period_select
    logic       scan_en_q;   // Scan form instead of serial
    logic       ack_q;       // Registered acknowledge
    logic [31:0] rdat_q;     // Registered read data

    // Per-port indicator lanes
    logic [7:0] act;         // Any traffic
    logic [7:0] col_b;       // Serial collision/duplex
    logic [7:0] la_b;        // Serial link/activity, 3/2-bit
    logic [7:0] spd_b;       // Serial speed
    logic [7:0] lab_b;       // Bi-color link/activity
    logic [7:0] spdb_b;      // Bi-color speed
    logic [7:0] comb_b;      // Serial combined indicator
    logic [7:0] col_s;       // Scan collision/duplex
    logic [7:0] la_s;        // Scan link/activity
    logic       blink;       // Selected blink phase

    // Serial shifter
    opled_sh_t   sh_q;       // Shifter state
    logic [23:0] frame_d;    // Assembled frame
    logic [23:0] frame_q;    // Frame being shifted
    logic [4:0]  nbits_d;    // Frame length by form
    logic [4:0]  nbits_q;    // Frame length held
    logic [4:0]  bit_q;      // Current bit index
    logic [7:0]  div_q;      // Cycles within one bit

    // Scan
    logic [2:0]  port_q;     // Scanned port
    logic [7:0]  sdiv_q;     // Cycles on current port

    opled_blink_if bl ();    // Shared timebase

    opled_blink #(
        .CYC_MS (CYC_MS)
    ) u_blink (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .bl    (bl)
    );

    // Strap pins are asynchronous; two stages before use
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            strap_m_q <= led_form_strap_i;
            strap_s_q <= strap_m_q;
        end
    end

    // Taken once just after reset release, then frozen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            form_q      <= FORM_3BIT;
            form_done_q <= 1'b0;
        end else if (ce_i && !form_done_q) begin
            form_q      <= strap_s_q;
            form_done_q <= 1'b1;
        end
    end

    // Zero picks the slow period; scan reuses it too
    assign blink = blink_sel_q ? bl.ph_fast : bl.ph_slow;
    assign act   = rx_act_i | tx_act_i;

    // Per-port indicator encodings, active low on serial except the bi-color pair
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Collision blinks, else duplex level
            assign col_b[p]  = col_i[p] ? blink : ~full_dup_i[p];
            // Low when linked, toggles with traffic
            assign la_b[p]   = link_i[p] ? (act[p] & blink) : 1'b1;
            // Low at 100M, high at 10M
            assign spd_b[p]  = ~spd100_i[p];
            // LED pair: link bit at 100M, speed bit at 10M
            assign lab_b[p]  = link_i[p] & ~(act[p] & blink) & spd100_i[p];
            assign spdb_b[p] = link_i[p] & ~(act[p] & blink) & ~spd100_i[p];
            // Speed picks its own period, ignoring select
            assign comb_b[p] = link_i[p] ? (act[p] & (spd100_i[p] ?
                               bl.ph_fast : bl.ph_slow)) : 1'b1;
            // Scan duplex high on full, blinks on collision
            assign col_s[p]  = col_i[p] ? blink : full_dup_i[p];
            // Scan link/activity high, dark blinks on traffic
            assign la_s[p]   = link_i[p] & ~(act[p] & blink);
        end
    endgenerate

    // Frame assembly, port 0 first, collision bit leads in 3-bit and bi-color
    always_comb begin
        frame_d = '0;
        nbits_d = 5'h18;
        for (int i = 0; i < NUM_PORTS; i++) begin
            case (form_q)
                FORM_3BIT: begin
                    frame_d[i*3]   = col_b[i];
                    frame_d[i*3+1] = la_b[i];
                    frame_d[i*3+2] = spd_b[i];
                end
                FORM_2BIT: begin
                    frame_d[i*2]   = spd_b[i];
                    frame_d[i*2+1] = la_b[i];
                end
                FORM_BI: begin
                    frame_d[i*3]   = col_b[i];
                    frame_d[i*3+1] = lab_b[i];
                    frame_d[i*3+2] = spdb_b[i];
                end
                default: begin
                    frame_d[i]     = comb_b[i];
                end
            endcase
        end
        case (form_q)
            FORM_2BIT: nbits_d = 5'h10;
            FORM_1BIT: nbits_d = 5'h08;
            default:   nbits_d = 5'h18;
        endcase
    end

    // Serial shifter: one frame per millisecond tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_q    <= SH_IDLE;
            frame_q <= '0;
            nbits_q <= '0;
            bit_q   <= '0;
            div_q   <= '0;
        end else if (ce_i) begin
            case (sh_q)
                SH_IDLE: begin
                    div_q <= '0;
                    bit_q <= '0;
                    if (bl.tick && !scan_en_q && form_done_q) begin
                        frame_q <= frame_d;
                        nbits_q <= nbits_d;
                        sh_q    <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    if (div_q == 8'(SH_DIV - 1)) begin
                        div_q <= '0;
                        if (bit_q == nbits_q - 5'h01) begin
                            sh_q <= SH_LATCH;
                        end else begin
                            bit_q <= bit_q + 5'h01;
                        end
                    end else begin
                        div_q <= div_q + 8'h1;
                    end
                end
                SH_LATCH: begin
                    if (div_q == 8'(SH_DIV - 1)) begin
                        div_q <= '0;
                        sh_q  <= SH_IDLE;
                    end else begin
                        div_q <= div_q + 8'h1;
                    end
                end
                default: sh_q <= SH_IDLE;
            endcase
        end
    end

    // Serial pins from flops; clock rises mid-bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_sclk_o  <= 1'b0;
            led_sdata_o <= 1'b1;
            led_latch_o <= 1'b0;
        end else if (ce_i) begin
            led_sclk_o  <= (sh_q == SH_SHIFT) && (div_q >= 8'(SH_DIV / 2));
            led_sdata_o <= (sh_q == SH_SHIFT) ? frame_q[bit_q] : 1'b1;
            led_latch_o <= (sh_q == SH_LATCH);
        end
    end

    // Scan walks ports at a fixed cadence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_q <= '0;
            sdiv_q <= '0;
        end else if (ce_i) begin
            if (sdiv_q == 8'(SC_DIV - 1)) begin
                sdiv_q <= '0;
                port_q <= port_q + 3'h1;
            end else begin
                sdiv_q <= sdiv_q + 8'h1;
            end
        end
    end

    // Scan lines by strap; reserved form stays dark
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_sel_o    <= '0;
            scan_status_o <= '0;
        end else if (ce_i) begin
            scan_sel_o    <= scan_en_q ? (8'h01 << port_q) : 8'h00;
            scan_status_o <= 3'h0;
            if (scan_en_q) begin
                case (form_q)
                    FORM_3BIT: scan_status_o <= {col_s[port_q],
                        la_s[port_q], spd100_i[port_q]};
                    FORM_2BIT: scan_status_o <= {rx_act_i[port_q],
                        tx_act_i[port_q], link_i[port_q]};
                    FORM_BI:   scan_status_o <= {1'b0,
                        lab_b[port_q], 1'b0};
                    default:   scan_status_o <= 3'h0;
                endcase
            end
        end
    end

    // Control register: byte lane 0 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_sel_q <= CTRL_BLINK_RST;
            scan_en_q   <= CTRL_SCAN_RST;
        end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_q && wb_we_i
                     && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            blink_sel_q <= wb_dat_i[CTRL_BLINK_BIT];
            scan_en_q   <= wb_dat_i[CTRL_SCAN_BIT];
        end
    end

    // Answer one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else if (ce_i) begin
            ack_q  <= wb_cyc_i && wb_stb_i && !ack_q;
            rdat_q <= '0;
            case (wb_adr_i)
                REG_CTRL:   rdat_q <= {30'h0, scan_en_q, blink_sel_q};
                REG_STATUS: rdat_q <= {27'h0, form_done_q, blink,
                                       sh_q != SH_IDLE, form_q};
                REG_PORTS:  rdat_q <= {16'h0, spd100_i, link_i};
                default:    rdat_q <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Sequence: frame begins from idle on a tick
    sequence s_frame_start;
        sh_q == SH_IDLE && bl.tick && !scan_en_q && form_done_q && ce_i;
    endsequence

    a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(form_done_q) |-> $stable(form_q))
        else $error("strap form changed after capture");
    a_frame_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_frame_start |=> sh_q == SH_SHIFT && bit_q == 5'h00)
        else $error("frame did not start at bit zero");
    a_sdata_order: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sh_q == SH_SHIFT |=> led_sdata_o == $past(frame_q[bit_q]))
        else $error("serial data not in frame order");
    a_col_duplex: assert property (@(posedge clk_i) disable iff (rst_i)
        (col_b & ~col_i) == (~full_dup_i & ~col_i))
        else $error("duplex bit wrong without collision");
    a_link_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (la_b & link_i & ~act) == 8'h00 && (la_b | link_i) == 8'hFF)
        else $error("link bit polarity wrong");
    a_bicolor_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        (lab_b & spdb_b) == 8'h00 &&
        lab_b == (link_i & spd100_i & ~(act & {8{blink}})))
        else $error("bi-color pair wrong");
    a_spd_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (spd_b ^ spd100_i) == 8'hFF)
        else $error("serial speed polarity wrong");
    a_comb_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (comb_b & link_i & ~act) == 8'h00)
        else $error("combined bit not low on idle link");
    a_blink_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        !blink_sel_q |-> blink == bl.ph_slow)
        else $error("cleared select not slow period");
    a_scan_rxtx: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && scan_en_q && form_q == FORM_2BIT |=>
        scan_status_o[2] == $past(rx_act_i[port_q]))
        else $error("scan receive line wrong");
endmodule

/* File: opled_led_model.sv */
`timescale 1ns/1ps
// External shift-and-latch LED chain fed by the serial wires
module opled_led_model (
    input  wire logic        sclk_i,  // Shift clock
    input  wire logic        sdata_i, // Serial data
    input  wire logic        latch_i, // Frame latch
    output logic      [23:0] frame_o, // Latched bits, first at 0
    output logic      [4:0]  nbits_o, // Bits in last frame
    output int               nfr_o    // Frames latched
);
    logic [23:0] sh_q;  // Bits shifted so far
    logic [4:0]  cnt_q; // Shift position
    // Empty chain at power-up
    initial begin
        sh_q = 24'h000000;
        cnt_q = 5'h00;
        frame_o = 24'h000000;
        nbits_o = 5'h00;
        nfr_o = 0;
    end
    // Take data on the rising shift edge; extra bits are dropped
    always @(posedge sclk_i) begin
        if (cnt_q < 5'h18) begin
            sh_q[cnt_q] <= sdata_i;
        end
        cnt_q <= cnt_q + 5'h01;
    end
    // Latch shows the frame and restarts the chain
    always @(posedge latch_i) begin
        frame_o <= sh_q;
        nbits_o <= cnt_q;
        cnt_q <= 5'h00;
        nfr_o <= nfr_o + 1;
    end
endmodule

/* File: opled_top_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the LED status block
module opled_top_bench;
    import opled_pkg::*;
    localparam int CMS = 64;  // Short millisecond keeps the run brief
    localparam int SHD = 2;   // Fast shift so a frame fits one tick
    localparam int SCD = 4;   // Fast scan cadence
    logic        clk_i, rst_i, ce_i;           // Clock, reset, enable
    logic [1:0]  strap;                        // Form strap pins
    logic [7:0]  link, spd, dup, col, rx, tx;  // Port status levels
    logic        cyc, stb, we, ack;            // Bus handshake
    logic [3:0]  adr, sel;                     // Address and lanes
    logic [31:0] wdat, rdat;                   // Write and read data
    logic        sclk, sdata, latch;           // Serial LED wires
    logic [7:0]  ssel;                         // Scanned port
    logic [2:0]  sstat;                        // Scan lines
    logic [23:0] frame;                        // Last latched frame
    logic [4:0]  nbits;                        // Its length
    int          nfr;                          // Frames seen
    int          n_fail = 0;                   // Mismatches
    int          comparisons = 0;              // Checks made
    int          cycles = 0;                   // Timeout counter
    logic [3:0]  lanes = 4'hF;                 // Byte lanes of next access

    opled_top #(.CYC_MS(CMS), .SH_DIV(SHD), .SC_DIV(SCD)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .led_form_strap_i(strap), .link_i(link), .spd100_i(spd),
        .full_dup_i(dup), .col_i(col), .rx_act_i(rx), .tx_act_i(tx),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .led_sclk_o(sclk), .led_sdata_o(sdata),
        .led_latch_o(latch), .scan_sel_o(ssel), .scan_status_o(sstat));
    opled_led_model leds (.sclk_i(sclk), .sdata_i(sdata),
        .latch_i(latch), .frame_o(frame), .nbits_o(nbits), .nfr_o(nfr));

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Cut a hang short well past the expected run length
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            $display("Error at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, exp, input string s);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask
    task automatic chk_true(input bit ok, input string s);
        comparisons++;
        if (!ok) begin
            n_fail++;
            $display("Error at %0t: %s", $time, s);
        end
    endtask
    // Classic single cycle; held until ack is seen at an edge
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk_true(k < 50, "no bus ack");
    endtask
    // Strap stays put across the whole reset
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk_i);
        strap <= m;
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic next_frame();
        int k, f;
        f = nfr;
        k = 0;
        while (nfr == f && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        chk_true(k < 400, "no serial frame");
    endtask
    // Quiet ports: every serial bit is active low except bi-color link and speed
    function automatic logic [23:0] exp_frame(input logic [1:0] m);
        logic [23:0] e;
        e = 24'h000000;
        for (int p = 0; p < 8; p++) begin
            case (m)
                2'h0, 2'h2: begin
                    e[3*p] = ~dup[p];
                    e[3*p+1] = (m == 2'h2) ? (link[p] & spd[p]) : ~link[p];
                    e[3*p+2] = (m == 2'h2) ? (link[p] & ~spd[p]) : ~spd[p];
                end
                2'h1: begin
                    e[2*p] = ~spd[p];
                    e[2*p+1] = ~link[p];
                end
                default: e[p] = ~link[p];
            endcase
        end
        return e;
    endfunction

    // Control reset value, port mirror, unmapped place
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk_word(q & 32'h3, 32'h1, "control reset");
        wb(1'b0, REG_PORTS, 32'h0, q);
        chk_word(q, {16'h0, spd, link}, "port mirror");
        wb(1'b0, 4'hC, 32'h0, q);
        chk_word(q, 32'h0, "unmapped read");
        wb(1'b1, REG_CTRL, 32'h0, q);
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk_word(q, 32'h0, "control write");
        wb(1'b1, REG_CTRL, 32'h1, q);
        // Lane 0 off: the write must leave control alone
        lanes = 4'hE;
        wb(1'b1, REG_CTRL, 32'h2, q);
        lanes = 4'hF;
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk_word(q, 32'h1, "lane 0 write");
    endtask
    // One strap form: latch check, serial frame, scan lines
    task automatic t_mode(input logic [1:0] m);
        logic [31:0] q;
        logic [23:0] mk;
        logic [2:0]  e;
        int k, n;
        n = (m == 2'h1) ? 16 : (m == 2'h3) ? 8 : 24;
        mk = 24'hFFFFFF >> (24 - n);
        do_reset(m);
        strap <= ~m;
        repeat (4) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk_word(q & 32'h13, {27'h0, 1'b1, 2'h0, m}, "strap held");
        repeat (2) next_frame();
        chk_word(32'(nbits), 32'(n), "frame length");
        q = 32'(frame & mk);
        chk_word(q, 32'(exp_frame(m)), "bits");
        // Traffic only in mode 1, so other forms keep steady lines
        rx <= (m == 2'h1) ? 8'h0F : 8'h00;
        tx <= (m == 2'h1) ? 8'h33 : 8'h00;
        wb(1'b1, REG_CTRL, 32'h3, q);
        for (int p = 0; p < 8; p++) begin
            k = 0;
            while (ssel !== (8'h01 << p) && k < 200) begin
                @(posedge clk_i);
                k++;
            end
            case (m)
                2'h0: e = {dup[p], link[p], spd[p]};
                2'h1: e = {rx[p], tx[p], link[p]};
                2'h2: e = {1'b0, link[p] & spd[p], 1'b0};
                default: e = 3'h0;
            endcase
            chk_word(32'(sstat), 32'(e), "scan");
        end
        wb(1'b1, REG_CTRL, 32'h1, q);
        rx <= 8'h00;
        tx <= 8'h00;
    endtask
    // Count changes of two frame bits over 100 ticks
    task automatic blink(input int a, b, output int ca, cb);
        logic [23:0] pv;
        ca = 0;
        cb = 0;
        repeat (2) next_frame();
        pv = frame;
        repeat (100) begin
            next_frame();
            ca += int'(frame[a] !== pv[a]);
            cb += int'(frame[b] !== pv[b]);
            pv = frame;
        end
    endtask
    // Collision on port 0, traffic on port 2, both periods
    task automatic t_blink();
        logic [31:0] q;
        int ca, cb;
        col <= 8'h01;
        rx <= 8'h04;
        blink(0, 7, ca, cb);
        chk_true(ca >= 2 && cb >= 2, "fast blink");
        wb(1'b1, REG_CTRL, 32'h0, q);
        blink(0, 7, ca, cb);
        chk_true(ca <= 1 && cb <= 1, "slow blink");
        col <= 8'h00;
        rx <= 8'h00;
    endtask
    // One-bit form: 100M port fast, 10M port slow, either setting
    task automatic t_comb();
        logic [31:0] q;
        int ca, cb;
        rx <= 8'h11;
        blink(4, 0, ca, cb);
        chk_true(ca >= 2 && cb <= 1, "combined blink");
        wb(1'b1, REG_CTRL, 32'h0, q);
        blink(4, 0, ca, cb);
        chk_true(ca >= 2 && cb <= 1, "combined ignores select");
        rx <= 8'h00;
    endtask

    // Main sequence
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        strap = 2'h0;
        link = 8'hF5;
        spd = 8'h3A;
        dup = 8'h96;
        col = 8'h00;
        rx = 8'h00;
        tx = 8'h00;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'hF;
        wdat = 32'h0;
        do_reset(2'h0);
        t_regs();
        for (int i = 0; i < 4; i++) begin
            t_mode(2'(i));
        end
        do_reset(2'h0);
        t_blink();
        do_reset(2'h3);
        t_comb();
        tally_and_finish();
    end
endmodule
